// ==== dv/rdb_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdb_regs_tb_top;
  import rdb_pkg::*;
  logic         clock      = 1'b0;
  logic         reset      = 1'b1;
  rdb_bus_req_t req        = '0;
  logic [31:0]  rdata;
  rdb_rev_cfg_t rev_cfg;
  logic [31:0]  startup_cfg;
  logic         brake_cap_invalid;
  logic [31:0]  d;
  logic [3:0]   i;
  int           mismatches = 0;
  int           num_checks = 0;

  always #12.5 clock = ~clock;

  rdb_regs i_rdb_regs (
    .clock             (clock),
    .reset             (reset),
    .bus_req           (req),
    .rdata             (rdata),
    .rev_cfg           (rev_cfg),
    .startup_cfg       (startup_cfg),
    .brake_cap_invalid (brake_cap_invalid)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each access ends one settle step after its edge, so outputs are stable.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #(25 * 2000);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk(rev_cfg, RDB_REV_CFG_RESET);
    chk(startup_cfg, 32'h0);
    rd_chk(RDB_STARTUP_OFFSET, 32'h0);
    rd_chk(RDB_REV_CFG_OFFSET, 32'h0);
    $display("Test reset values done");
    // Every code of both acceleration fields and of the current cap.
    for (int k = 0; k < 16; k++)
    begin
      i = k[3:0];
      d = {i[0], i, ~i, i[2:0], i[1:0], i, i, ~i, ~i, ~i[1:0]};
      wr(RDB_REV_CFG_OFFSET, d);
      chk(rev_cfg, d);
      chk(rev_cfg.brake_loop_proportional_gain, d[19:10]);
      chk(brake_cap_invalid, i[2:0] == 3'h7);
      rd_chk(RDB_REV_CFG_OFFSET, d);
    end
    $display("Test field codes done");
    wr(RDB_STARTUP_OFFSET, 32'hffff_ffff);
    chk(startup_cfg, 32'hffff_fff7);
    rd_chk(RDB_STARTUP_OFFSET, 32'hffff_fff7);
    @(posedge clock);
    #1;
    chk(rdata, 32'h0);
    chk(rev_cfg, d);
    $display("Test start-up register done");
    wr(8'h80, 32'h1234_5678);
    rd_chk(8'h80, 32'h0);
    chk(rev_cfg, d);
    chk(startup_cfg, 32'hffff_fff7);
    $display("Test unmapped offset done");
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    #1;
    chk(rev_cfg, 32'h0);
    chk(brake_cap_invalid, 1'b0);
    chk(startup_cfg, 32'h0);
    rd_chk(RDB_STARTUP_OFFSET, 32'h0);
    $display("Test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== include/rdb_pkg.sv ====
// Notes on behaviour
// - Bits 30-27 hold linear acceleration code, reset zero.
// - Bits 26-23 hold quadratic acceleration code.
// - Bits 22-20 hold brake current cap code.
// - Bits 19-10 hold proportional gain, scale 2^7.
// - Bits 9-0 hold integral gain, scale 2^9.
// - Start-up register at 84h, resets all zero.
`default_nettype none
package rdb_pkg;
  localparam logic [7:0]  RDB_REV_CFG_OFFSET    = 8'h82;
  localparam logic [7:0]  RDB_STARTUP_OFFSET    = 8'h84;
  localparam logic [31:0] RDB_REV_CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] RDB_STARTUP_RESET     = 32'h0000_0000;
  localparam logic [31:0] RDB_STARTUP_WMASK     = 32'hffff_fff7;
  localparam int          RDB_PARITY_BIT        = 31;
  localparam int          RDB_LIN_ACCEL_LSB     = 27;
  localparam int          RDB_QUAD_ACCEL_LSB    = 23;
  localparam int          RDB_BRAKE_CAP_LSB     = 20;
  localparam int          RDB_KP_LSB            = 10;
  localparam int          RDB_KI_LSB            = 0;
  localparam int          RDB_KP_FRAC_BITS      = 7;
  localparam int          RDB_KI_FRAC_BITS      = 9;
  localparam logic [2:0]  RDB_BRAKE_CAP_INVALID = 3'h7;

  typedef struct packed {
    logic       parity;
    logic [3:0] reverse_open_loop_linear_accel;
    logic [3:0] reverse_open_loop_quadratic_accel;
    logic [2:0] brake_bus_current_cap;
    logic [9:0] brake_loop_proportional_gain;
    logic [9:0] brake_loop_integral_gain;
  } rdb_rev_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rdb_bus_req_t;
endpackage
`default_nettype wire

// ==== logic/rdb_regs.sv ====
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rdb_regs
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Register port
  input  wire rdb_pkg::rdb_bus_req_t bus_req,
  output var  logic [31:0]           rdata,
  // Settings to the control loops
  output var  rdb_pkg::rdb_rev_cfg_t rev_cfg,
  output var  logic [31:0]           startup_cfg,
  output var  logic                  brake_cap_invalid
);
  import rdb_pkg::*;

  rdb_rev_cfg_t rev_q, rev_d;
  logic [31:0]  start_q, start_d;
  logic [31:0]  rdata_q, rdata_d;
  logic         inval_q, inval_d;

  // Decoding is shared by the write and read paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  always_comb
  begin
    rev_d   = rev_q;
    start_d = start_q;
    rdata_d = 32'h0000_0000;
    if (bus_req.wr && hit(bus_req.addr, RDB_REV_CFG_OFFSET))
    begin
      rev_d = rdb_rev_cfg_t'(bus_req.wdata);
    end
    // Bit 3 of the start-up register is read-only and stays zero.
    if (bus_req.wr && hit(bus_req.addr, RDB_STARTUP_OFFSET))
    begin
      start_d = bus_req.wdata & RDB_STARTUP_WMASK;
    end
    // Unmapped reads return zero so software never sees stale data.
    if (bus_req.rd && hit(bus_req.addr, RDB_REV_CFG_OFFSET))
    begin
      rdata_d = rev_q;
    end
    else if (bus_req.rd && hit(bus_req.addr, RDB_STARTUP_OFFSET))
    begin
      rdata_d = start_q;
    end
    inval_d = (rev_d.brake_bus_current_cap == RDB_BRAKE_CAP_INVALID);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rev_q   <= rdb_rev_cfg_t'(RDB_REV_CFG_RESET);
      start_q <= RDB_STARTUP_RESET;
      rdata_q <= 32'h0000_0000;
      inval_q <= 1'b0;
    end
    else
    begin
      rev_q   <= rev_d;
      start_q <= start_d;
      rdata_q <= rdata_d;
      inval_q <= inval_d;
    end
  end

  assign rdata             = rdata_q;
  assign rev_cfg           = rev_q;
  assign startup_cfg       = start_q;
  assign brake_cap_invalid = inval_q;

  property p_rev_write;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == RDB_REV_CFG_OFFSET
    |=> rev_cfg == $past(bus_req.wdata);
  endproperty
  a_rev_write: assert property (p_rev_write)
    else $error("reverse config write lost");

  property p_gain_fields;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == RDB_REV_CFG_OFFSET
    |=> rev_cfg.brake_loop_proportional_gain == $past(bus_req.wdata[19:10])
        && rev_cfg.brake_loop_integral_gain == $past(bus_req.wdata[9:0]);
  endproperty
  a_gain_fields: assert property (p_gain_fields)
    else $error("gain field misplaced");

  property p_accel_fields;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == RDB_REV_CFG_OFFSET
    |=> rev_cfg.reverse_open_loop_linear_accel == $past(bus_req.wdata[30:27])
     && rev_cfg.reverse_open_loop_quadratic_accel
        == $past(bus_req.wdata[26:23]);
  endproperty
  a_accel_fields: assert property (p_accel_fields)
    else $error("accel field misplaced");

  property p_cap_field;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == RDB_REV_CFG_OFFSET
    |=> rev_cfg.brake_bus_current_cap == $past(bus_req.wdata[22:20])
        && brake_cap_invalid
           == ($past(bus_req.wdata[22:20]) == RDB_BRAKE_CAP_INVALID);
  endproperty
  a_cap_field: assert property (p_cap_field)
    else $error("brake cap field wrong");

  property p_parity_plain;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == RDB_REV_CFG_OFFSET
    |=> rev_cfg.parity == $past(bus_req.wdata[31]);
  endproperty
  a_parity_plain: assert property (p_parity_plain)
    else $error("parity bit not stored");

  property p_reset_zero;
    @(posedge clock) reset
    |=> rev_cfg == RDB_REV_CFG_RESET && startup_cfg == RDB_STARTUP_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");

  property p_startup_read;
    @(posedge clock) disable iff (reset)
    bus_req.rd && bus_req.addr == RDB_STARTUP_OFFSET
    |=> rdata == $past(startup_cfg);
  endproperty
  a_startup_read: assert property (p_startup_read)
    else $error("start-up read wrong");

  property p_hold;
    @(posedge clock) disable iff (reset)
    !bus_req.wr ##1 !bus_req.wr |-> $stable(rev_cfg) && $stable(startup_cfg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without write");

  property p_unmapped;
    @(posedge clock) disable iff (reset)
    bus_req.rd && bus_req.addr != RDB_STARTUP_OFFSET
    && bus_req.addr != RDB_REV_CFG_OFFSET |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_rev_read;
    @(posedge clock) disable iff (reset)
    bus_req.rd && bus_req.addr == RDB_REV_CFG_OFFSET
    |=> rdata == $past(rev_cfg);
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("reverse config read wrong");

  // Idle read data must be zero, or a late sample could pass by luck.
  property p_rdata_idle;
    @(posedge clock) disable iff (reset)
    !bus_req.rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data held past its cycle");

  property p_startup_write;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr == RDB_STARTUP_OFFSET
    |=> startup_cfg == ($past(bus_req.wdata) & RDB_STARTUP_WMASK);
  endproperty
  a_startup_write: assert property (p_startup_write)
    else $error("start-up write lost");

  property p_startup_ro_bit;
    @(posedge clock) disable iff (reset)
    startup_cfg[3] == 1'b0;
  endproperty
  a_startup_ro_bit: assert property (p_startup_ro_bit)
    else $error("read-only start-up bit set");

  property p_cap_flag_level;
    @(posedge clock) disable iff (reset)
    brake_cap_invalid
    == (rev_cfg.brake_bus_current_cap == RDB_BRAKE_CAP_INVALID);
  endproperty
  a_cap_flag_level: assert property (p_cap_flag_level)
    else $error("cap flag out of step");

  property p_rev_isolated;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr != RDB_REV_CFG_OFFSET |=> $stable(rev_cfg);
  endproperty
  a_rev_isolated: assert property (p_rev_isolated)
    else $error("reverse config hit by other write");

  property p_startup_isolated;
    @(posedge clock) disable iff (reset)
    bus_req.wr && bus_req.addr != RDB_STARTUP_OFFSET
    |=> $stable(startup_cfg);
  endproperty
  a_startup_isolated: assert property (p_startup_isolated)
    else $error("start-up register hit by other write");

  // A read must never disturb the values that it reports.
  property p_read_no_side_effect;
    @(posedge clock) disable iff (reset)
    bus_req.rd |=> $stable(rev_cfg) && $stable(startup_cfg);
  endproperty
  a_read_no_side_effect: assert property (p_read_no_side_effect)
    else $error("read changed a register");

  c_rev_wr_rd: cover property (@(posedge clock)
    bus_req.wr && bus_req.addr == RDB_REV_CFG_OFFSET ##1
    bus_req.rd && bus_req.addr == RDB_REV_CFG_OFFSET);
  c_start_wr: cover property (@(posedge clock)
    bus_req.wr && bus_req.addr == RDB_STARTUP_OFFSET);
  c_invalid: cover property (@(posedge clock) brake_cap_invalid);
  c_start_rd: cover property (@(posedge clock)
    bus_req.rd && bus_req.addr == RDB_STARTUP_OFFSET);
  c_mid_reset: cover property (@(posedge clock) !reset ##1 reset);
endmodule
`default_nettype wire
